// [src/pci_chan.sv]
// Purpose: One pin change detector channel with its flag
// Assumes: Pin is synchronous to clock
// Notes:   First cycle after reset sees a high pin as a rising edge, history starts at zero
`timescale 1ns/1ns
module pci_chan #(
  parameter int unsigned CH = 0
) (
  // System
  input  wire logic clock,
  input  wire logic rst_b,
  // Channel bundle
  pci_chan_if.chan  bus
);
  logic prev_q;
  logic lvl_prev_q;
  logic flag_q;
  logic flag_d;
  wire  pin_now   = bus.pin[CH];
  wire  rise      = pin_now & ~prev_q;
  wire  fall      = ~pin_now & prev_q;
  wire  edge_hit  = (bus.rise_en[CH] & rise) | (bus.fall_en[CH] & fall);
  wire  level_hit = (bus.rise_en[CH] & pin_now) | (bus.fall_en[CH] & ~pin_now);
  wire  is_edge   = (bus.edge_mode[CH] == pci_pkg::TRIG_EDGE);
  // Level event is the rising of the level request, not the level itself
  wire  lvl_rise  = level_hit & ~lvl_prev_q;

  // Edge mode: write loads, hardware set wins; level mode: flag is inverse pin
  always_comb begin
    flag_d = flag_q;
    if (is_edge) begin
      if (bus.flag_wr[CH]) begin
        flag_d = bus.flag_wdat[CH];
      end
      if (edge_hit) begin
        flag_d = 1'b1;
      end
    end else begin
      flag_d = ~pin_now;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      prev_q     <= 1'b0;
      lvl_prev_q <= 1'b0;
      flag_q     <= 1'b0;
    end else begin
      prev_q     <= pin_now;
      lvl_prev_q <= level_hit;
      flag_q     <= flag_d;
    end
  end

  assign bus.flag[CH] = flag_q;
  assign bus.req[CH]  = is_edge ? flag_q : level_hit;
  assign bus.evt[CH]  = is_edge ? edge_hit : lvl_rise;
endmodule : pci_chan

// [src/pci_chan_if.sv]
// Purpose: Bundle between the register file and the channel detectors
// Assumes: One bit of each vector per channel
// Notes:   Top drives controls, channels return flag state and events
`timescale 1ns/1ns
interface pci_chan_if;
  logic [pci_pkg::NUM_CH-1:0] pin;
  logic [pci_pkg::NUM_CH-1:0] rise_en;
  logic [pci_pkg::NUM_CH-1:0] fall_en;
  logic [pci_pkg::NUM_CH-1:0] edge_mode;
  logic [pci_pkg::NUM_CH-1:0] flag_wr;
  logic [pci_pkg::NUM_CH-1:0] flag_wdat;
  logic [pci_pkg::NUM_CH-1:0] flag;
  logic [pci_pkg::NUM_CH-1:0] req;
  logic [pci_pkg::NUM_CH-1:0] evt;

  modport ctrl (output pin, rise_en, fall_en, edge_mode, flag_wr, flag_wdat,
                input  flag, req, evt);
  modport chan (input  pin, rise_en, fall_en, edge_mode, flag_wr, flag_wdat,
                output flag, req, evt);
endinterface : pci_chan_if

// [src/pci_pkg.sv]
// Purpose: Constants for the eight-channel pin change interrupt block
// Assumes: Register index times four gives the Wishbone byte address
// Notes:   All registers are 8 bits wide and sit in data bits 7:0
package pci_pkg;
  localparam int unsigned NUM_CH     = 8;
  localparam int unsigned NUM_PORTS  = 4;
  localparam int unsigned ADR_W      = 10;
  localparam int unsigned IDX_W      = 8;
  localparam int unsigned DAT_W      = 32;
  localparam int unsigned REG_W      = 8;

  // Register indexes; byte address is index times four
  localparam logic [7:0] IDX_CONTROL   = 8'hE9;
  localparam logic [7:0] IDX_FALL_EN   = 8'hEA;
  localparam logic [7:0] IDX_RISE_EN   = 8'hEB;
  localparam logic [7:0] IDX_FLAGS     = 8'hEC;
  localparam logic [7:0] IDX_PRIO_LOW  = 8'hEF;
  localparam logic [7:0] IDX_PRIO_HIGH = 8'hF8;
  localparam logic [7:0] IDX_EVT_STAT  = 8'hF9;
  localparam logic [7:0] IDX_EVT_MASK  = 8'hFA;
  localparam logic [7:0] IDX_PIN_LEVEL = 8'hFB;

  // Control register fields
  localparam int unsigned PORT_SEL_LSB = 0;
  localparam int unsigned PORT_SEL_W   = 2;
  localparam int unsigned TRIG_CH0     = 2;
  localparam int unsigned TRIG_CH1     = 3;
  localparam int unsigned TRIG_CH2     = 4;
  localparam int unsigned TRIG_CH3     = 5;
  localparam int unsigned TRIG_CH45    = 6;
  localparam int unsigned TRIG_CH67    = 7;

  // Priority register bit for this source
  localparam int unsigned PRIO_BIT     = 1;

  // Reset values
  localparam logic [7:0] RST_CONTROL   = 8'h00;
  localparam logic [7:0] RST_ENABLE    = 8'h00;
  localparam logic [7:0] RST_FLAGS     = 8'h00;
  localparam logic [7:0] RST_PRIO      = 8'h00;
  localparam logic [7:0] RST_MASK      = 8'h00;

  // Trigger type encodings
  localparam logic TRIG_LEVEL = 1'b0;
  localparam logic TRIG_EDGE  = 1'b1;
endpackage : pci_pkg

// [src/pci_top.sv]
// Purpose: Eight-channel pin change interrupt detector with Wishbone registers
// Assumes: Port pins are synchronous to clock; classic Wishbone slave
// Notes:   Registers are 8 bits in data bits 7:0, upper bits read zero
// Operation
// - Per-channel enable arms high level or rising edge detection.
// - Trigger type bit picks level or edge for both polarity enables.
// - Edge mode: hardware sets flag on enabled edge; flag stays set.
// - Edge mode flag is read-write; software clears it, hardware never does.
// - Level mode: flag continuously shows inverse of selected pin level.
// - Level mode: flag is read-only, software writes ignored.
// - Pin source priority low bit sits at bit 1 of priority register.
// - Reset clears rising enables and all flags to zero.
// - Trigger bit zero is level, one is edge; 4/5 and 6/7 share.
// - Two-bit port select picks port 0 to 3 as channel inputs.
// - Second per-channel enable arms low level or falling edge detection.
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
module pci_top #(
  parameter int unsigned NUM_CH    = pci_pkg::NUM_CH,
  parameter int unsigned NUM_PORTS = pci_pkg::NUM_PORTS
) (
  // System
  input  wire logic                        clock,
  input  wire logic                        rst_b,
  // Wishbone slave
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [pci_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [pci_pkg::DAT_W-1:0]   wb_dat_i,
  output logic      [pci_pkg::DAT_W-1:0]   wb_dat_o,
  output logic                             wb_ack_o,
  // General purpose port pins, port n in bits 8n+7:8n
  input  wire logic [NUM_PORTS*NUM_CH-1:0] port_pins,
  // Toward the CPU interrupt logic
  output logic                             pin_irq_req,
  output logic      [1:0]                  pin_irq_prio,
  output logic                             irq
);

  // Elaboration checks
  if (NUM_CH != pci_pkg::NUM_CH) begin : g_chk_ch
    $error("pci_top: channel count must equal eight");
  end
  if (NUM_PORTS != pci_pkg::NUM_PORTS) begin : g_chk_ports
    $error("pci_top: port count must equal four");
  end

  localparam int unsigned RW = pci_pkg::REG_W;

  // Register state
  logic [RW-1:0]              control_q;
  logic [RW-1:0]              control_d;
  logic [RW-1:0]              fall_low_enable_reg_q;
  logic [RW-1:0]              fall_low_enable_reg_d;
  logic [RW-1:0]              rise_high_enable_reg_q;
  logic [RW-1:0]              rise_high_enable_reg_d;
  logic [RW-1:0]              extended_priority_low_reg_q;
  logic [RW-1:0]              extended_priority_low_reg_d;
  logic [RW-1:0]              extended_priority_high_reg_q;
  logic [RW-1:0]              extended_priority_high_reg_d;
  logic [RW-1:0]              evt_mask_q;
  logic [RW-1:0]              evt_mask_d;

  // Bus state
  logic                       ack_q;
  logic [pci_pkg::DAT_W-1:0]  rdata_q;
  logic [pci_pkg::DAT_W-1:0]  rdata_d;

  // Output state
  logic                       pin_irq_req_q;
  logic [1:0]                 pin_irq_prio_q;
  logic                       irq_q;

  // Status block results
  logic [RW-1:0]              evt_stat;
  logic                       evt_any;

  pci_chan_if chans ();

  // Bus decode
  wire                        access   = wb_cyc_i & wb_stb_i & ~ack_q;
  wire                        wr_acc   = access & wb_we_i & wb_sel_i[0];
  wire                        rd_acc   = access & ~wb_we_i;
  wire [pci_pkg::IDX_W-1:0]   reg_idx  = wb_adr_i[pci_pkg::IDX_W+1:2];
  wire [RW-1:0]               wbyte    = wb_dat_i[RW-1:0];

  wire hit_control   = (reg_idx == pci_pkg::IDX_CONTROL);
  wire hit_fall_en   = (reg_idx == pci_pkg::IDX_FALL_EN);
  wire hit_rise_en   = (reg_idx == pci_pkg::IDX_RISE_EN);
  wire hit_flags     = (reg_idx == pci_pkg::IDX_FLAGS);
  wire hit_prio_low  = (reg_idx == pci_pkg::IDX_PRIO_LOW);
  wire hit_prio_high = (reg_idx == pci_pkg::IDX_PRIO_HIGH);
  wire hit_evt_stat  = (reg_idx == pci_pkg::IDX_EVT_STAT);
  wire hit_evt_mask  = (reg_idx == pci_pkg::IDX_EVT_MASK);
  wire hit_pin_level = (reg_idx == pci_pkg::IDX_PIN_LEVEL);

  wire wr_control    = wr_acc & hit_control;
  wire wr_fall_en    = wr_acc & hit_fall_en;
  wire wr_rise_en    = wr_acc & hit_rise_en;
  wire wr_flags      = wr_acc & hit_flags;
  wire wr_prio_low   = wr_acc & hit_prio_low;
  wire wr_prio_high  = wr_acc & hit_prio_high;
  wire wr_evt_stat   = wr_acc & hit_evt_stat;
  wire wr_evt_mask   = wr_acc & hit_evt_mask;

  // Control register fields
  wire [pci_pkg::PORT_SEL_W-1:0] port_select_field =
    control_q[pci_pkg::PORT_SEL_LSB +: pci_pkg::PORT_SEL_W];
  wire trigger_type_bit_0  = control_q[pci_pkg::TRIG_CH0];
  wire trigger_type_bit_1  = control_q[pci_pkg::TRIG_CH1];
  wire trigger_type_bit_2  = control_q[pci_pkg::TRIG_CH2];
  wire trigger_type_bit_3  = control_q[pci_pkg::TRIG_CH3];
  wire trigger_type_bit_45 = control_q[pci_pkg::TRIG_CH45];
  wire trigger_type_bit_67 = control_q[pci_pkg::TRIG_CH67];

  // Per-channel trigger type, shared bits fanned out
  wire [NUM_CH-1:0] edge_mode = {trigger_type_bit_67, trigger_type_bit_67,
                                 trigger_type_bit_45, trigger_type_bit_45,
                                 trigger_type_bit_3,  trigger_type_bit_2,
                                 trigger_type_bit_1,  trigger_type_bit_0};

  // Port select
  wire [NUM_CH-1:0] port0 = port_pins[0*NUM_CH +: NUM_CH];
  wire [NUM_CH-1:0] port1 = port_pins[1*NUM_CH +: NUM_CH];
  wire [NUM_CH-1:0] port2 = port_pins[2*NUM_CH +: NUM_CH];
  wire [NUM_CH-1:0] port3 = port_pins[3*NUM_CH +: NUM_CH];
  wire [NUM_CH-1:0] sel_pins =
    (port_select_field == 2'h0) ? port0 :
    (port_select_field == 2'h1) ? port1 :
    (port_select_field == 2'h2) ? port2 : port3;

  // Channel bundle drive
  assign chans.pin       = sel_pins;
  assign chans.rise_en   = rise_high_enable_reg_q;
  assign chans.fall_en   = fall_low_enable_reg_q;
  assign chans.edge_mode = edge_mode;
  assign chans.flag_wr   = {NUM_CH{wr_flags}} & edge_mode;
  assign chans.flag_wdat = wbyte;

  // One detector per channel
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
    pci_chan #(
      .CH    (ch)
    ) u_chan (
      .clock (clock),
      .rst_b (rst_b),
      .bus   (chans)
    );
  end

  // Sticky event status, masked onto irq
  pci_w1c #(
    .W       (RW)
  ) u_evt (
    .clock   (clock),
    .rst_b   (rst_b),
    .evt     (chans.evt),
    .clr_wr  (wr_evt_stat),
    .clr_dat (wbyte),
    .mask    (evt_mask_q),
    .stat    (evt_stat),
    .any     (evt_any)
  );

  // Register next values
  assign control_d = wr_control ? wbyte : control_q;
  assign fall_low_enable_reg_d = wr_fall_en ? wbyte : fall_low_enable_reg_q;
  assign rise_high_enable_reg_d = wr_rise_en ? wbyte : rise_high_enable_reg_q;
  assign extended_priority_low_reg_d =
    wr_prio_low ? wbyte : extended_priority_low_reg_q;
  assign extended_priority_high_reg_d =
    wr_prio_high ? wbyte : extended_priority_high_reg_q;
  assign evt_mask_d = wr_evt_mask ? wbyte : evt_mask_q;

  // Read data select, unmapped reads return zero
  wire [RW-1:0] rd_byte =
    hit_control   ? control_q :
    hit_fall_en   ? fall_low_enable_reg_q :
    hit_rise_en   ? rise_high_enable_reg_q :
    hit_flags     ? chans.flag :
    hit_prio_low  ? extended_priority_low_reg_q :
    hit_prio_high ? extended_priority_high_reg_q :
    hit_evt_stat  ? evt_stat :
    hit_evt_mask  ? evt_mask_q :
    hit_pin_level ? sel_pins : pci_pkg::RST_FLAGS;

  assign rdata_d = rd_acc ? {{(pci_pkg::DAT_W-RW){1'b0}}, rd_byte} : '0;

  // Priority level of the pin source, high bit then low bit
  wire [1:0] prio_d = {extended_priority_high_reg_q[pci_pkg::PRIO_BIT],
                       extended_priority_low_reg_q[pci_pkg::PRIO_BIT]};

  // Combined request toward the CPU
  wire req_d = |chans.req;

  // Configuration registers
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      control_q              <= pci_pkg::RST_CONTROL;
      fall_low_enable_reg_q  <= pci_pkg::RST_ENABLE;
      rise_high_enable_reg_q <= pci_pkg::RST_ENABLE;
    end else begin
      control_q              <= control_d;
      fall_low_enable_reg_q  <= fall_low_enable_reg_d;
      rise_high_enable_reg_q <= rise_high_enable_reg_d;
    end
  end

  // Priority and mask registers
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      extended_priority_low_reg_q  <= pci_pkg::RST_PRIO;
      extended_priority_high_reg_q <= pci_pkg::RST_PRIO;
      evt_mask_q                   <= pci_pkg::RST_MASK;
    end else begin
      extended_priority_low_reg_q  <= extended_priority_low_reg_d;
      extended_priority_high_reg_q <= extended_priority_high_reg_d;
      evt_mask_q                   <= evt_mask_d;
    end
  end

  // Bus answer: ack one cycle after the request appears
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q   <= access;
      rdata_q <= rdata_d;
    end
  end

  // Registered outputs
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pin_irq_req_q  <= 1'b0;
      pin_irq_prio_q <= 2'h0;
      irq_q          <= 1'b0;
    end else begin
      pin_irq_req_q  <= req_d;
      pin_irq_prio_q <= prio_d;
      irq_q          <= evt_any;
    end
  end

  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = rdata_q;
  assign pin_irq_req  = pin_irq_req_q;
  assign pin_irq_prio = pin_irq_prio_q;
  assign irq          = irq_q;

endmodule : pci_top

// [src/pci_w1c.sv]
// Purpose: Sticky event status with write-one-to-clear and a mask
// Assumes: Write strobes are single cycle
// Notes:   A new event in the clearing cycle keeps its bit set
`timescale 1ns/1ns
module pci_w1c #(
  parameter int unsigned W = 8
) (
  // System
  input  wire logic         clock,
  input  wire logic         rst_b,
  // Events and software access
  input  wire logic [W-1:0] evt,
  input  wire logic         clr_wr,
  input  wire logic [W-1:0] clr_dat,
  input  wire logic [W-1:0] mask,
  // State
  output logic      [W-1:0] stat,
  output logic              any
);
  logic [W-1:0] stat_q;
  wire  [W-1:0] clr   = clr_wr ? clr_dat : '0;
  wire  [W-1:0] stat_d = (stat_q & ~clr) | evt;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      stat_q <= '0;
    end else begin
      stat_q <= stat_d;
    end
  end

  assign stat = stat_q;
  assign any  = |(stat_q & mask);
endmodule : pci_w1c

// [verification/pci_pins_model.sv]
// Purpose: Port pins of the surrounding circuitry
// Assumes: Pins are synchronous to the system clock
// Notes:   Levels always driven, so no release state exists
`timescale 1ns/1ns
module pci_pins_model #(
  parameter int unsigned W = 32
) (
  // System
  input  wire logic         clock,
  // Requested and driven levels
  input  wire logic [W-1:0] want,
  output logic      [W-1:0] port_pins
);
  // Change just after an edge so the block never sees a mid-cycle step
  initial port_pins = '0;
  always @(posedge clock) port_pins <= want;
endmodule : pci_pins_model

// [verification/pci_top_monitor.sv]
// Purpose: Port-level checks for the pin change interrupt block
// Assumes: Bound to pci_top, one clock domain
// Notes:   Request and irq may only move shortly after a write or pin change
`timescale 1ns/1ns
module pci_top_monitor #(
  parameter int unsigned NUM_CH    = 8,
  parameter int unsigned NUM_PORTS = 4
) (
  // System
  input wire logic                        clock,
  input wire logic                        rst_b,
  // Wishbone
  input wire logic                        wb_cyc_i,
  input wire logic                        wb_stb_i,
  input wire logic                        wb_we_i,
  input wire logic [pci_pkg::ADR_W-1:0]   wb_adr_i,
  input wire logic [3:0]                  wb_sel_i,
  input wire logic [pci_pkg::DAT_W-1:0]   wb_dat_i,
  input wire logic [pci_pkg::DAT_W-1:0]   wb_dat_o,
  input wire logic                        wb_ack_o,
  // Pins and interrupt side
  input wire logic [NUM_PORTS*NUM_CH-1:0] port_pins,
  input wire logic                        pin_irq_req,
  input wire logic [1:0]                  pin_irq_prio,
  input wire logic                        irq
);
  logic [NUM_PORTS*NUM_CH-1:0] pins_prev_q;
  logic [3:0]                  quiet_q;
  wire                         cause_w = (wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i)
                                         | (port_pins != pins_prev_q);

  // Cycles since the last cause that may move an output
  always_ff @(posedge clock) begin
    pins_prev_q <= port_pins;
    quiet_q     <= (!rst_b || cause_w) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_wr(idx);
    s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == idx);
  endsequence

  a_ack_latency: assert property (s_take |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=>
    (!wb_ack_o && !pin_irq_req && !irq && pin_irq_prio == 2'b00))
    else $error("outputs not cleared by reset");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_prio_low: assert property (s_wr(pci_pkg::IDX_PRIO_LOW) |-> ##2
    pin_irq_prio[0] == $past(wb_dat_i[1], 2))
    else $error("priority low bit not taken from bit 1");
  a_prio_high: assert property (s_wr(pci_pkg::IDX_PRIO_HIGH) |-> ##2
    pin_irq_prio[1] == $past(wb_dat_i[1], 2))
    else $error("priority high bit not taken from bit 1");
  a_req_cause: assert property ($changed(pin_irq_req) |-> quiet_q < 4'h4)
    else $error("request moved without a write or pin change");
  a_irq_cause: assert property ($changed(irq) |-> quiet_q < 4'h5)
    else $error("irq moved without a write or pin change");
endmodule : pci_top_monitor

bind pci_top pci_top_monitor #(.NUM_CH(NUM_CH), .NUM_PORTS(NUM_PORTS)) i_mon (
  .clock(clock), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_pins(port_pins),
  .pin_irq_req(pin_irq_req), .pin_irq_prio(pin_irq_prio), .irq(irq));

// [verification/pci_top_tb_top.sv]
// Purpose: Register-level tests of the pin change interrupt block
// Assumes: Classic Wishbone single cycles, pins via the pin model
// Notes:   Port 0 held high at reset so level flags read zero
`timescale 1ns/1ns
module pci_top_tb_top;
  logic        clock;
  logic        rst_b;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [9:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [31:0] pins_want;
  logic [31:0] port_pins;
  logic        pin_irq_req;
  logic [1:0]  pin_irq_prio;
  logic        irq;
  logic [31:0] junk;
  int          error_cnt;
  int          num_checks;
  int          cyc_cnt;

  pci_pins_model #(.W(32)) i_pins (.clock(clock), .want(pins_want), .port_pins(port_pins));
  pci_top i_dut (
    .clock(clock), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_pins(port_pins),
    .pin_irq_req(pin_irq_req), .pin_irq_prio(pin_irq_prio), .irq(irq));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk_reg(input logic [7:0] idx, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED reg %h expected %h seen %h", idx, exp, got);
    end
  endtask : chk_reg

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_bit

  task automatic wb_acc(input logic we, input logic [7:0] idx, input logic [3:0] sel,
                        input logic [7:0] wd, output logic [31:0] rd);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= sel;
    wb_dat_i <= {24'h0, wd};
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    // One idle edge so registered outputs reflect the access when checked
    @(posedge clock);
  endtask : wb_acc

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    wb_acc(1'b1, idx, 4'hF, wd, junk);
  endtask : wr

  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    wb_acc(1'b0, idx, 4'hF, 8'h00, junk);
    chk_reg(idx, exp, junk);
  endtask : rchk

  task automatic pins(input logic [31:0] v);
    @(posedge clock);
    pins_want <= v;
    repeat (5) @(posedge clock);
  endtask : pins

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  initial begin
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    pins_want = 32'h0000_00FF;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    rchk(pci_pkg::IDX_CONTROL, 32'h0);
    rchk(pci_pkg::IDX_RISE_EN, 32'h0);
    rchk(pci_pkg::IDX_FLAGS, 32'h0);
    rchk(pci_pkg::IDX_PRIO_LOW, 32'h0);
    chk_bit("req", 1'b0, pin_irq_req);
    wb_acc(1'b1, pci_pkg::IDX_RISE_EN, 4'h0, 8'hFF, junk);
    wr(8'h10, 8'hFF);
    rchk(pci_pkg::IDX_RISE_EN, 32'h0);
    rchk(8'h10, 32'h0);
    $display("test reset done");
    wr(pci_pkg::IDX_PRIO_LOW, 8'h02);
    rchk(pci_pkg::IDX_PRIO_LOW, 32'h02);
    chk_bit("prio low", 1'b1, pin_irq_prio[0]);
    wr(pci_pkg::IDX_PRIO_HIGH, 8'h02);
    wr(pci_pkg::IDX_PRIO_LOW, 8'hFD);
    chk_bit("prio low", 1'b0, pin_irq_prio[0]);
    chk_bit("prio high", 1'b1, pin_irq_prio[1]);
    $display("test priority done");
    wr(pci_pkg::IDX_RISE_EN, 8'hFF);
    for (int p = 0; p < 4; p++) begin
      wr(pci_pkg::IDX_CONTROL, {6'h3F, p[1:0]});
      pins(32'h0);
      wr(pci_pkg::IDX_FLAGS, 8'h00);
      pins(~(32'hFF << (8 * p)) | (32'h81 << (8 * p)));
      rchk(pci_pkg::IDX_FLAGS, 32'h81);
      chk_bit("req", 1'b1, pin_irq_req);
    end
    pins(32'h0);
    rchk(pci_pkg::IDX_FLAGS, 32'h81);
    wr(pci_pkg::IDX_FLAGS, 8'h00);
    rchk(pci_pkg::IDX_FLAGS, 32'h0);
    chk_bit("req", 1'b0, pin_irq_req);
    $display("test rise edge done");
    wr(pci_pkg::IDX_RISE_EN, 8'h00);
    wr(pci_pkg::IDX_FALL_EN, 8'hFF);
    wr(pci_pkg::IDX_CONTROL, 8'hFC);
    pins(32'h0000_00FF);
    wr(pci_pkg::IDX_FLAGS, 8'h00);
    wr(pci_pkg::IDX_EVT_STAT, 8'hFF);
    rchk(pci_pkg::IDX_FLAGS, 32'h0);
    pins(32'h0);
    rchk(pci_pkg::IDX_FLAGS, 32'hFF);
    wr(pci_pkg::IDX_EVT_MASK, 8'h00);
    chk_bit("irq", 1'b0, irq);
    wr(pci_pkg::IDX_EVT_MASK, 8'h01);
    chk_bit("irq", 1'b1, irq);
    wr(pci_pkg::IDX_EVT_STAT, 8'hFF);
    rchk(pci_pkg::IDX_EVT_STAT, 32'h0);
    chk_bit("irq", 1'b0, irq);
    rchk(pci_pkg::IDX_FLAGS, 32'hFF);
    $display("test fall edge done");
    wr(pci_pkg::IDX_FALL_EN, 8'h00);
    wr(pci_pkg::IDX_RISE_EN, 8'hFF);
    wr(pci_pkg::IDX_CONTROL, 8'h50);
    wr(pci_pkg::IDX_FLAGS, 8'h00);
    rchk(pci_pkg::IDX_FLAGS, 32'hCB);
    pins(32'h0000_00FF);
    rchk(pci_pkg::IDX_FLAGS, 32'h34);
    rchk(pci_pkg::IDX_EVT_STAT, 32'hFF);
    rchk(pci_pkg::IDX_PIN_LEVEL, 32'hFF);
    chk_bit("req", 1'b1, pin_irq_req);
    wr(pci_pkg::IDX_FLAGS, 8'hFF);
    rchk(pci_pkg::IDX_FLAGS, 32'h34);
    wr(pci_pkg::IDX_FLAGS, 8'h00);
    rchk(pci_pkg::IDX_FLAGS, 32'h0);
    $display("test mixed mode done");
    stop_test();
  end
endmodule : pci_top_tb_top
